// ---- sfp_pkg.sv ----
package sfp_pkg;

  // ----------------------------------------------------------------
  // Widths and array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic [5:0] BLOCK64_COUNT = 6'h3F;
  localparam logic [ADDR_W-1:0] SECTOR_4K_MASK = 24'hFFF000;
  localparam logic [ADDR_W-1:0] BLOCK_32K_MASK = 24'hFF8000;
  localparam logic [ADDR_W-1:0] BLOCK_64K_MASK = 24'hFF0000;
  localparam logic [ADDR_W-1:0] AAI_STEP = 24'h000002;

  // ----------------------------------------------------------------
  // Status byte layout and reset values
  // ----------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 5;
  localparam int ST_AAI = 6;
  localparam int ST_LOCK = 7;
  localparam logic [3:0] BP_RESET = 4'h7;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_BYTE_PROG = 8'h02;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
  localparam logic [7:0] OP_BUSY_PIN_ON = 8'h70;
  localparam logic [7:0] OP_BUSY_PIN_OFF = 8'h80;
  localparam logic [7:0] OP_AUTO_INC_PROG = 8'hAD;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;

  // ----------------------------------------------------------------
  // Request to the array back end
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    REQ_PROG_BYTE = 2'h0,
    REQ_PROG_WORD = 2'h1,
    REQ_ERASE = 2'h3,
    REQ_ERASE_CHIP = 2'h2
  } sfp_req_kind_type;

  typedef struct packed {
    sfp_req_kind_type kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [1:0] size;
  } sfp_req_type;

  localparam int REQ_W = $bits(sfp_req_type);

endpackage

// ---- sfp_fifo.sv ----
`timescale 1ns/10ps
module sfp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;

  wire push = in_valid_i && in_ready_o;
  wire load = (count != '0) && (!out_valid_o || out_ready_i);

  assign in_ready_o = (count != CW'(DEPTH));

  // Output stage is a register so the drain side sees flopped data
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr <= PW'(wr_ptr + 1'b1);
      end
      if (load) begin
        out_data_o <= mem[rd_ptr];
        rd_ptr <= PW'(rd_ptr + 1'b1);
        out_valid_o <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
      count <= CW'(count + CW'(push) - CW'(load));
    end
  end

endmodule

// ---- sfp_flash_front.sv ----
`timescale 1ns/10ps
// Function
// - Serial modes 0 and 3 both work with no configuration.
// - Command, address and data bits are taken on rising serial clock.
// - Serial output changes to the next bit on falling serial clock.
// - A new command starts only on a falling chip select.
// - With busy pin enabled, output shows busy state during auto-increment programming.
// - Write-protect pin level enables or disables the lock bit's effect.
// - Pause suspends the transfer without deselect; sequence continues afterwards.
// - Array has 4K sectors plus aligned 32K and 64K erase blocks.
// - Write completion is seen by polling busy, or by watching serial output during auto-increment programming.
// - Auto-increment word programming advances the address after each word.
// - Program and erase are blocked in regions chosen by protection bits.
// - Pause begins only while the clock is low at or after pause falls.
// - While paused the output floats and input and clock are ignored.
// - With protect pin low and lock bit set, status write is rejected.
module sfp_flash_front (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  // Serial pins
  input wire logic SCK_I,
  input wire logic CE_B_I,
  input wire logic SI_I,
  input wire logic HOLD_B_I,
  input wire logic WP_B_I,
  output logic SO_O,
  output logic SO_OE_B_O,
  // Array back end
  input wire logic ARRAY_BUSY_I,
  output sfp_pkg::sfp_req_type REQ_O,
  output logic REQ_VALID_O,
  input wire logic REQ_READY_I,
  // Status
  output logic [7:0] STATUS_O,
  output logic PAUSED_O
);
  import sfp_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic sck_prev;
  logic ce_prev;

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pin_meta <= 5'h1B;
      pin_sync <= 5'h1B;
    end else begin
      pin_meta <= {SCK_I, CE_B_I, SI_I, HOLD_B_I, WP_B_I};
      pin_sync <= pin_meta;
    end
  end

  wire sck_s = pin_sync[4];
  wire ce_b_s = pin_sync[3];
  wire si_s = pin_sync[2];
  wire hold_b_s = pin_sync[1];
  wire wp_b_s = pin_sync[0];

  // ----------------------------------------------------------------
  // Framing and pause
  // ----------------------------------------------------------------
  logic paused;
  wire selected = !ce_b_s;
  wire frame_start = ce_prev && !ce_b_s;
  // Edges are taken only from the clock's own levels, so idle level is free
  wire sck_rise = selected && !paused && sck_s && !sck_prev;
  wire sck_fall = selected && !paused && !sck_s && sck_prev;

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sck_prev <= 1'b1;
      ce_prev <= 1'b1;
      paused <= 1'b0;
    end else begin
      sck_prev <= sck_s;
      ce_prev <= ce_b_s;
      if (!selected) begin
        paused <= 1'b0;
      end else if (!sck_s) begin
        paused <= !hold_b_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shift-in and byte counting
  // ----------------------------------------------------------------
  logic [6:0] shift_in;
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic active;
  logic [7:0] op;
  logic [ADDR_W-1:0] addr;
  logic [7:0] data_hi;

  wire [7:0] rx_byte = {shift_in, si_s};
  wire byte_done = sck_rise && active && (bit_cnt == 3'h7);
  wire [7:0] cur_op = (byte_cnt == 3'h0) ? rx_byte : op;

  // ----------------------------------------------------------------
  // Status state
  // ----------------------------------------------------------------
  logic wel;
  logic auto_increment_program_mode;
  logic lock_bit;
  logic [3:0] bp;
  logic busy_pin_en;
  wire fifo_ready;
  wire busy = ARRAY_BUSY_I || REQ_VALID_O || !fifo_ready;
  wire [7:0] status = {lock_bit, auto_increment_program_mode, bp, wel, busy};

  // ----------------------------------------------------------------
  // Protection decode
  // ----------------------------------------------------------------
  // Protected area grows from the top of the array in 64K blocks
  wire [6:0] prot_span = (bp == 4'h0) ? 7'h00 : (7'h01 << (bp - 4'h1));
  wire [6:0] prot_base = 7'h40 - prot_span;
  wire addr_prot = (bp >= 4'h7) || ({1'b0, addr[21:16]} >= prot_base);
  wire [ADDR_W-1:0] next_addr = {addr[15:0], rx_byte};
  wire next_prot = (bp >= 4'h7) || ({1'b0, next_addr[21:16]} >= prot_base);
  wire sr_write_ok = wel && (wp_b_s || !lock_bit);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire at_op = byte_done && (byte_cnt == 3'h0);
  wire is_erase = (cur_op == OP_SECTOR_ERASE) || (cur_op == OP_BLOCK32_ERASE) ||
                  (cur_op == OP_BLOCK64_ERASE);
  wire erase_go = byte_done && is_erase && (byte_cnt == 3'h3) && wel && !busy && !next_prot;
  wire chip_go = at_op && (cur_op == OP_CHIP_ERASE) && wel && !busy && (bp == 4'h0);
  wire byte_go = byte_done && (cur_op == OP_BYTE_PROG) && (byte_cnt == 3'h4) && wel &&
                 !busy && !addr_prot;
  // First auto-increment word carries the address; later ones only data
  wire aai_first = byte_done && (cur_op == OP_AUTO_INC_PROG) && !auto_increment_program_mode &&
                   (byte_cnt == 3'h5) && wel && !busy;
  wire aai_next = byte_done && (cur_op == OP_AUTO_INC_PROG) && auto_increment_program_mode &&
                  (byte_cnt == 3'h2) && !busy;
  wire aai_go = (aai_first || aai_next) && !addr_prot;
  wire aai_stop = (aai_first || aai_next) && addr_prot;
  wire [ADDR_W-1:0] erase_mask = (cur_op == OP_SECTOR_ERASE) ? SECTOR_4K_MASK :
                                 (cur_op == OP_BLOCK32_ERASE) ? BLOCK_32K_MASK :
                                 BLOCK_64K_MASK;

  sfp_req_type push_word;
  wire push = erase_go || chip_go || byte_go || aai_go;

  assign push_word.kind = (erase_go) ? REQ_ERASE :
                          (chip_go) ? REQ_ERASE_CHIP :
                          (aai_go) ? REQ_PROG_WORD : REQ_PROG_BYTE;
  assign push_word.addr = erase_go ? (next_addr & erase_mask) : addr;
  assign push_word.data = aai_go ? {data_hi, rx_byte} : {8'h00, rx_byte};
  assign push_word.size = (cur_op == OP_SECTOR_ERASE) ? 2'h0 :
                          (cur_op == OP_BLOCK32_ERASE) ? 2'h1 : 2'h2;

  // ----------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      shift_in <= '0;
      bit_cnt <= '0;
      byte_cnt <= '0;
      active <= 1'b0;
      op <= '0;
      addr <= '0;
      data_hi <= '0;
    end else if (!selected) begin
      bit_cnt <= '0;
      byte_cnt <= '0;
      active <= 1'b0;
    end else if (frame_start) begin
      bit_cnt <= '0;
      byte_cnt <= '0;
      active <= 1'b1;
    end else if (sck_rise && active) begin
      shift_in <= rx_byte[6:0];
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_done) begin
        if (byte_cnt != 3'h7) begin
          byte_cnt <= byte_cnt + 3'h1;
        end
        if (byte_cnt == 3'h0) begin
          op <= rx_byte;
        end
        if (!auto_increment_program_mode && byte_cnt >= 3'h1 && byte_cnt <= 3'h3) begin
          addr <= next_addr;
        end
        if ((auto_increment_program_mode && byte_cnt == 3'h1) || (!auto_increment_program_mode && byte_cnt == 3'h4)) begin
          data_hi <= rx_byte;
        end
        if (aai_go) begin
          addr <= addr + AAI_STEP;
        end
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wel <= 1'b0;
      auto_increment_program_mode <= 1'b0;
      lock_bit <= 1'b0;
      bp <= BP_RESET;
      busy_pin_en <= 1'b0;
    end else if (at_op) begin
      case (rx_byte)
        OP_WRITE_ENABLE: wel <= 1'b1;
        OP_WRITE_DISABLE: begin
          wel <= 1'b0;
          auto_increment_program_mode <= 1'b0;
        end
        OP_BUSY_PIN_ON: busy_pin_en <= 1'b1;
        OP_BUSY_PIN_OFF: busy_pin_en <= 1'b0;
        OP_CHIP_ERASE: wel <= chip_go ? 1'b0 : wel;
        default: wel <= wel;
      endcase
    end else if (byte_done && cur_op == OP_STATUS_WRITE && byte_cnt == 3'h1) begin
      if (sr_write_ok) begin
        bp <= rx_byte[ST_BP_HI:ST_BP_LO];
        lock_bit <= rx_byte[ST_LOCK];
      end
      wel <= 1'b0;
    end else if (erase_go || byte_go || aai_stop) begin
      wel <= 1'b0;
      auto_increment_program_mode <= 1'b0;
    end else if (aai_first && !addr_prot) begin
      auto_increment_program_mode <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  logic [7:0] tx;
  logic tx_en;
  wire show_busy = selected && auto_increment_program_mode && busy_pin_en && !tx_en;

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      tx <= '0;
      tx_en <= 1'b0;
      SO_O <= 1'b0;
      SO_OE_B_O <= 1'b1;
    end else begin
      if (!selected) begin
        tx_en <= 1'b0;
      end else if (at_op && rx_byte == OP_STATUS_READ) begin
        tx <= status;
        tx_en <= 1'b1;
      end else if (sck_fall && tx_en) begin
        SO_O <= tx[7];
        tx <= {tx[6:0], status[7]};
      end else if (show_busy) begin
        SO_O <= !busy;
      end
      // Output floats whenever paused or idle
      SO_OE_B_O <= !(selected && !paused && (tx_en || show_busy));
    end
  end

  // ----------------------------------------------------------------
  // Request queue and status outputs
  // ----------------------------------------------------------------
  sfp_fifo #(
    .WIDTH(REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_req_fifo (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .in_valid_i(push),
    .in_data_i(push_word),
    .in_ready_o(fifo_ready),
    .out_valid_o(REQ_VALID_O),
    .out_data_o(REQ_O),
    .out_ready_i(REQ_READY_I)
  );

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      STATUS_O <= {1'b0, 1'b0, BP_RESET, 1'b0, 1'b0};
      PAUSED_O <= 1'b0;
    end else begin
      STATUS_O <= status;
      PAUSED_O <= paused;
    end
  end

endmodule

// ---- sfp_front_monitor.sv ----
`timescale 1ns/10ps
module sfp_front_monitor
  import sfp_pkg::*;
(
  // Pins
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic SCK_I,
  input wire logic CE_B_I,
  input wire logic HOLD_B_I,
  input wire logic WP_B_I,
  input wire logic SO_O,
  input wire logic SO_OE_B_O,
  input wire logic PAUSED_O,
  // Back end and status
  input wire logic ARRAY_BUSY_I,
  input wire logic REQ_READY_I,
  input wire logic REQ_VALID_O,
  input wire sfp_pkg::sfp_req_type REQ_O,
  input wire logic [7:0] STATUS_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);
  property p_rst; $rose(RST_B_I) |-> STATUS_O == 8'h1C && SO_OE_B_O && !REQ_VALID_O; endproperty
  a_rst: assert property (p_rst) else $error("bad value after reset");
  property p_idle; CE_B_I [*5] |-> SO_OE_B_O; endproperty
  a_idle: assert property (p_idle) else $error("output driven while deselected");
  property p_hold; REQ_VALID_O && !REQ_READY_I |=> REQ_VALID_O && $stable(REQ_O); endproperty
  a_hold: assert property (p_hold) else $error("request dropped before taken");
  property p_take; $fell(REQ_VALID_O) |-> $past(REQ_READY_I); endproperty
  a_take: assert property (p_take) else $error("request vanished untaken");
  property p_busy; (REQ_VALID_O || ARRAY_BUSY_I) [*3] |-> STATUS_O[ST_BUSY]; endproperty
  a_busy: assert property (p_busy) else $error("busy flag not shown");
  // Busy pin output is not tied to the clock edges: watch driven status reads only
  property p_fall;
    !CE_B_I && !SO_OE_B_O && !STATUS_O[ST_AAI] && $rose(SCK_I) |=> $stable(SO_O) [*5];
  endproperty
  a_fall: assert property (p_fall) else $error("output moved after rising clock");
  property p_float; PAUSED_O [*2] |-> SO_OE_B_O; endproperty
  a_float: assert property (p_float) else $error("output driven while paused");
  property p_enter;
    $rose(PAUSED_O) |-> !$past(CE_B_I, 3) && (!$past(SCK_I, 2) || !$past(SCK_I, 3));
  endproperty
  a_enter: assert property (p_enter) else $error("pause entered with clock high");
  property p_leave; (HOLD_B_I && !SCK_I) [*6] |-> !PAUSED_O; endproperty
  a_leave: assert property (p_leave) else $error("pause not left");
  property p_lock;
    (!WP_B_I && STATUS_O[ST_LOCK]) [*4] |=> $stable({STATUS_O[7], STATUS_O[5:2]});
  endproperty
  a_lock: assert property (p_lock) else $error("locked protection bits changed");
  c_pause: cover property ($rose(PAUSED_O));
  c_req: cover property (REQ_VALID_O && REQ_READY_I);
  c_drive: cover property ($fell(SO_OE_B_O));
endmodule
bind sfp_flash_front sfp_front_monitor mon (
  .MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .SCK_I(SCK_I), .CE_B_I(CE_B_I),
  .HOLD_B_I(HOLD_B_I), .WP_B_I(WP_B_I), .SO_O(SO_O), .SO_OE_B_O(SO_OE_B_O),
  .PAUSED_O(PAUSED_O), .ARRAY_BUSY_I(ARRAY_BUSY_I), .REQ_READY_I(REQ_READY_I),
  .REQ_VALID_O(REQ_VALID_O), .REQ_O(REQ_O), .STATUS_O(STATUS_O)
);

// ---- sfp_host_model.sv ----
`timescale 1ns/10ps
module sfp_host_model (
  // Clock
  input wire logic mclk_i,
  // From the device
  input wire logic so_i,
  input wire logic so_oe_b_i,
  input wire logic paused_i,
  // To the device
  output logic sck_o,
  output logic ce_b_o,
  output logic si_o,
  output logic hold_b_o,
  output logic wp_b_o
);
  logic mode3, p_seen, oe_seen;
  logic so_w;
  // Released line has no pull: show the inverse so a float is caught
  assign so_w = so_oe_b_i ? ~so_i : so_i;
  initial begin
    mode3 = 1'b0;
    sck_o = 1'b0;
    ce_b_o = 1'b1;
    si_o = 1'b0;
    hold_b_o = 1'b1;
    wp_b_o = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic sel();
    sck_o = mode3;
    w(2);
    ce_b_o = 1'b0;
    w(4);
  endtask
  task automatic desel();
    w(4);
    ce_b_o = 1'b1;
    w(6);
  endtask
  // Wiggle the clock while held; it must be ignored
  task automatic pause();
    hold_b_o = 1'b0;
    w(6);
    p_seen = paused_i;
    oe_seen = so_oe_b_i;
    sck_o = 1'b1;
    w(4);
    sck_o = 1'b0;
    w(4);
    hold_b_o = 1'b1;
    w(6);
  endtask
  task automatic xfer(input logic [7:0] d, input int nb, input int hb, output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i >= 8 - nb; i--) begin
      sck_o = 1'b0;
      si_o = d[i];
      w(4);
      if (i == hb) pause();
      r = {r[6:0], so_w};
      sck_o = 1'b1;
      w(4);
    end
    if (!mode3) begin
      sck_o = 1'b0;
      w(4);
    end
  endtask
endmodule

// ---- sfp_flash_front_tb.sv ----
`timescale 1ns/10ps
module sfp_flash_front_tb;
  import sfp_pkg::*;
  logic mclk, rst_b, sck, ce_b, si, hold_b, wp_b, so, so_oe_b, rdy, req_valid, paused, abusy;
  logic [7:0] status;
  logic [7:0] r;
  sfp_req_type req;
  int bad_count, n_checks;
  logic [7:0] ops [3] = '{OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE};
  logic [23:0] masks [3] = '{SECTOR_4K_MASK, BLOCK_32K_MASK, BLOCK_64K_MASK};
  sfp_flash_front dut (
    .MCLK_I(mclk), .RST_B_I(rst_b), .SCK_I(sck), .CE_B_I(ce_b), .SI_I(si),
    .HOLD_B_I(hold_b), .WP_B_I(wp_b), .SO_O(so), .SO_OE_B_O(so_oe_b),
    .ARRAY_BUSY_I(abusy), .REQ_O(req), .REQ_VALID_O(req_valid), .REQ_READY_I(rdy),
    .STATUS_O(status), .PAUSED_O(paused)
  );
  sfp_host_model host (
    .mclk_i(mclk), .so_i(so), .so_oe_b_i(so_oe_b), .paused_i(paused), .sck_o(sck),
    .ce_b_o(ce_b), .si_o(si), .hold_b_o(hold_b), .wp_b_o(wp_b)
  );
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmd(input logic [47:0] v, input int n);
    host.sel();
    for (int i = n - 1; i >= 0; i--) begin
      host.xfer(v[i*8+:8], 8, 9, r);
    end
    host.desel();
  endtask
  task automatic rd_status(input logic m, input int hb, input logic [7:0] e);
    host.mode3 = m;
    host.sel();
    host.xfer(OP_STATUS_READ, 8, 9, r);
    host.xfer(8'h00, 8, hb, r);
    host.desel();
    chk(r, e);
  endtask
  task automatic status_write_command(input logic [7:0] v, input logic [7:0] e);
    cmd(OP_WRITE_ENABLE, 1);
    cmd({OP_STATUS_WRITE, v}, 2);
    chk(status, e);
  endtask
  // Far side stalls a while before taking each request
  task automatic take(input sfp_req_kind_type k, input logic [23:0] a, input logic [15:0] d,
                      input logic [1:0] s);
    int t;
    t = 0;
    while (req_valid !== 1'b1 && t < 300) begin
      host.w(1);
      t++;
    end
    if (t == 300) begin
      bad_count++;
      conclude();
    end else begin
      host.w(6);
      chk(req.kind, k);
      if (k != REQ_ERASE_CHIP) chk(req.addr, a);
      if (k == REQ_ERASE) chk(req.size, s);
      if (k == REQ_PROG_WORD || k == REQ_PROG_BYTE) chk(req.data, d);
      rdy = 1'b1;
      host.w(1);
      rdy = 1'b0;
    end
  endtask
  initial begin
    bad_count = 0;
    n_checks = 0;
    rst_b = 1'b0;
    rdy = 1'b0;
    abusy = 1'b0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    host.w(4);
    chk(status, 8'h1C);
    rd_status(1'b0, 9, 8'h1C);
    rd_status(1'b1, 3, 8'h1C);
    chk({host.p_seen, host.oe_seen}, 2'b11);
    $display("test modes_pause done");
    host.sel();
    host.xfer(OP_WRITE_ENABLE, 4, 9, r);
    host.desel();
    cmd(OP_WRITE_ENABLE, 1);
    chk(status[ST_WEL], 1'b1);
    cmd({OP_BYTE_PROG, 24'h001000, 8'hA5}, 5);
    host.w(20);
    chk(req_valid, 1'b0);
    $display("test framing_protect done");
    status_write_command(8'h00, 8'h00);
    status_write_command(8'h80, 8'h80);
    host.wp_b_o = 1'b0;
    status_write_command(8'h1C, 8'h80);
    host.wp_b_o = 1'b1;
    status_write_command(8'h00, 8'h00);
    $display("test lock done");
    for (int i = 0; i < 3; i++) begin
      cmd(OP_WRITE_ENABLE, 1);
      cmd({ops[i], 24'h3A5678}, 4);
      take(REQ_ERASE, 24'h3A5678 & masks[i], 16'h0000, 2'(i));
    end
    cmd(OP_WRITE_ENABLE, 1);
    cmd({OP_BYTE_PROG, 24'h123456, 8'hA5}, 5);
    take(REQ_PROG_BYTE, 24'h123456, 16'h00A5, 2'h0);
    $display("test erase_program done");
    cmd(OP_BUSY_PIN_ON, 1);
    cmd(OP_WRITE_ENABLE, 1);
    cmd({OP_AUTO_INC_PROG, 24'h001000, 16'hC35A}, 6);
    chk(status[ST_AAI], 1'b1);
    host.sel();
    host.w(4);
    chk({so_oe_b, so}, 2'b00);
    host.desel();
    take(REQ_PROG_WORD, 24'h001000, 16'hC35A, 2'h0);
    host.sel();
    host.w(6);
    chk({so_oe_b, so}, 2'b01);
    host.desel();
    cmd({OP_AUTO_INC_PROG, 16'h1234}, 3);
    take(REQ_PROG_WORD, 24'h001002, 16'h1234, 2'h0);
    cmd(OP_BUSY_PIN_OFF, 1);
    host.sel();
    host.w(6);
    chk(so_oe_b, 1'b1);
    host.desel();
    cmd(OP_WRITE_DISABLE, 1);
    chk(status[ST_AAI], 1'b0);
    $display("test auto_increment done");
    abusy = 1'b1;
    host.w(3);
    chk(status[ST_BUSY], 1'b1);
    rd_status(1'b1, 9, 8'h01);
    cmd(OP_WRITE_ENABLE, 1);
    cmd(OP_CHIP_ERASE, 1);
    host.w(20);
    chk(req_valid, 1'b0);
    abusy = 1'b0;
    cmd(OP_CHIP_ERASE, 1);
    take(REQ_ERASE_CHIP, 24'h000000, 16'h0000, 2'h0);
    host.w(4);
    chk(status, 8'h00);
    $display("test busy_chip done");
    conclude();
  end
endmodule
